// *** smgm_regs.svh ***
// constants for the splice message gpio matcher
// Behaviour
// R1: dtmf enabled: match, emit dtmf after preroll
// R2: splice id enabled: fire only on equal
// R3: program id enabled: fire only on equal
// R4: start normal accepted: fire before splice point
// R5: start immediate accepted: fire at splice point
// R6: end normal accepted: fire before splice ends
// R7: end immediate accepted: fire at end
// R8: unaccepted splice types never trigger
// R9: cancel enabled: revoke last issued trigger
// R10: ignore preroll set: act at once
// R11: ignore preroll clear: wait preroll first
// R12: signed ms delay shifts preroll start
// R13: all enabled criteria hold on one message
`ifndef SMGM_REGS_SVH
`define SMGM_REGS_SVH
`define SMGM_CLK_PERIOD_NS   20
`define SMGM_MS_NS           1000000
`define SMGM_CYC_PER_MS      ((`SMGM_MS_NS + `SMGM_CLK_PERIOD_NS - 1) / `SMGM_CLK_PERIOD_NS)
`define SMGM_PULSE_MS        1000
// accept mask bit positions
`define SMGM_ACC_START_NORMAL 0
`define SMGM_ACC_START_IMM    1
`define SMGM_ACC_END_NORMAL   2
`define SMGM_ACC_END_IMM      3
// configuration reset values
`define SMGM_ACCEPT_RST       4'h3
`define SMGM_DELAY_RST        16'h0000
`define SMGM_ID_RST           16'h0000
`define SMGM_DTMF_RST         32'h0000_0000
`endif

// *** smgm_pkg.sv ***
// types shared by the splice message gpio matcher
package smgm_pkg;
  typedef enum logic [2:0] {
    SPL_START_NORMAL,
    SPL_START_IMM,
    SPL_END_NORMAL,
    SPL_END_IMM,
    SPL_CANCEL
  } smgm_splice_t;

  typedef struct packed {
    smgm_splice_t splice_type;
    logic [15:0]  splice_id;
    logic [15:0]  program_id;
    logic [31:0]  dtmf;
    logic [15:0]  preroll_ms;
  } smgm_msg_t;

  typedef struct packed {
    logic               dtmf_en;
    logic [31:0]        dtmf_val;
    logic               sid_en;
    logic [15:0]        sid_val;
    logic               pid_en;
    logic [15:0]        pid_val;
    logic [3:0]         accept;
    logic               cancel_en;
    logic               ignore_preroll;
    logic signed [15:0] delay_ms;
  } smgm_cfg_t;
endpackage : smgm_pkg

// *** smgm_ms_timer.sv ***
// millisecond countdown timer with a one-cycle expiry pulse
`timescale 1ns/100ps
module smgm_ms_timer #(
  parameter int CYC_PER_MS = 50000,
  parameter int MS_W       = 18
) (
  input  wire logic            clk,
  input  wire logic            rstn,
  input  wire logic            load,
  input  wire logic [MS_W-1:0] load_ms,
  input  wire logic            abort,
  output logic                 expire
);
  localparam int CYC_W = $clog2(CYC_PER_MS + 1);
  localparam logic [CYC_W-1:0] CYC_LAST = CYC_W'(CYC_PER_MS - 1);

  logic            active_r,  active_nxt;
  logic [MS_W-1:0] ms_r,      ms_nxt;
  logic [CYC_W-1:0] cyc_r,    cyc_nxt;
  logic            expire_r,  expire_nxt;

  always_comb begin
    active_nxt = active_r;
    ms_nxt     = ms_r;
    cyc_nxt    = cyc_r;
    expire_nxt = 1'b0;
    // a fresh load wins over an expiry in the same cycle
    if (load) begin
      active_nxt = 1'b1;
      ms_nxt     = load_ms;
      cyc_nxt    = '0;
    end else if (abort) begin
      active_nxt = 1'b0;
    end else if (active_r) begin
      if (ms_r == '0) begin
        active_nxt = 1'b0;
        expire_nxt = 1'b1;
      end else if (cyc_r == CYC_LAST) begin
        cyc_nxt = '0;
        ms_nxt  = ms_r - MS_W'(1);
      end else begin
        cyc_nxt = cyc_r + CYC_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      active_r <= 1'b0;
      ms_r     <= '0;
      cyc_r    <= '0;
      expire_r <= 1'b0;
    end else begin
      active_r <= active_nxt;
      ms_r     <= ms_nxt;
      cyc_r    <= cyc_nxt;
      expire_r <= expire_nxt;
    end
  end

  assign expire = expire_r;
endmodule : smgm_ms_timer

// *** smgm_matcher.sv ***
// splice message decoder driving one gpio trigger output
`timescale 1ns/100ps
`include "smgm_regs.svh"
module smgm_matcher #(
  parameter int CYC_PER_MS = `SMGM_CYC_PER_MS,
  parameter int PULSE_MS   = `SMGM_PULSE_MS
) (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              msg_valid,
  input  wire smgm_pkg::smgm_msg_t msg,
  input  wire logic              cfg_wr,
  input  wire smgm_pkg::smgm_cfg_t cfg_in,
  output smgm_pkg::smgm_cfg_t    cfg_out,
  output logic                   gpio_out,
  output logic                   dtmf_valid,
  output logic [31:0]            dtmf_out,
  output logic                   pending,
  output logic                   cancelled
);
  // wide enough for the longest preroll plus the largest positive delay
  localparam int MS_W = 18;

  // wait holds pending high, pulse holds the gpio high
  typedef enum {
    ST_IDLE,
    ST_WAIT,
    ST_PULSE
  } smgm_state_t;

  // id criteria shared by triggers and cancels
  function automatic logic ids_match(input smgm_pkg::smgm_cfg_t c,
                                     input smgm_pkg::smgm_msg_t m);
    logic ok;
    ok = 1'b1;
    if (c.sid_en && (m.splice_id != c.sid_val)) ok = 1'b0;  // see R2
    if (c.pid_en && (m.program_id != c.pid_val)) ok = 1'b0; // see R3
    return ok;
  endfunction : ids_match

  // countdown before the trigger fires, in whole milliseconds
  function automatic logic [MS_W-1:0] wait_ms(input smgm_pkg::smgm_cfg_t c,
                                              input smgm_pkg::smgm_msg_t m);
    logic signed [MS_W:0] sum;
    sum = '0;
    case (m.splice_type)
      smgm_pkg::SPL_START_NORMAL,
      smgm_pkg::SPL_END_NORMAL: begin
        if (!c.ignore_preroll) begin // see R10, R11
          // see R12
          sum = $signed({3'h0, m.preroll_ms}) + (MS_W + 1)'(c.delay_ms);
        end
      end
      default: sum = '0; // see R5, R7
    endcase
    // a delay earlier than the message itself cannot be honoured
    if (sum < 0) sum = '0;
    return sum[MS_W-1:0];
  endfunction : wait_ms

  smgm_pkg::smgm_cfg_t cfg_r, cfg_nxt;
  smgm_state_t         state_r, state_nxt;
  logic                gpio_r, gpio_nxt;
  logic                dvalid_r, dvalid_nxt;
  logic [31:0]         dtmf_r, dtmf_nxt;
  logic [31:0]         dhold_r, dhold_nxt;
  logic                dsend_r, dsend_nxt;
  logic                pend_r, pend_nxt;
  logic                canc_r, canc_nxt;
  logic                tmr_load;
  logic [MS_W-1:0]     tmr_ms;
  logic                tmr_abort;
  logic                tmr_expire;
  logic                type_ok;
  logic                hit;
  logic                cancel_hit;

  // a write lands whole, so fields never mix old and new settings
  always_comb begin
    cfg_nxt = cfg_r;
    if (cfg_wr) cfg_nxt = cfg_in;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      // start types accepted out of reset, end types not
      cfg_r                <= '0;
      cfg_r.dtmf_val       <= `SMGM_DTMF_RST;
      cfg_r.sid_val        <= `SMGM_ID_RST;
      cfg_r.pid_val        <= `SMGM_ID_RST;
      cfg_r.accept         <= `SMGM_ACCEPT_RST; // see R4, R5, R6, R7
      cfg_r.delay_ms       <= `SMGM_DELAY_RST;  // see R12
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // cancel and unused codes never arm the trigger
  always_comb begin
    case (msg.splice_type)
      smgm_pkg::SPL_START_NORMAL: type_ok = cfg_r.accept[`SMGM_ACC_START_NORMAL]; // see R4
      smgm_pkg::SPL_START_IMM:    type_ok = cfg_r.accept[`SMGM_ACC_START_IMM];    // see R5
      smgm_pkg::SPL_END_NORMAL:   type_ok = cfg_r.accept[`SMGM_ACC_END_NORMAL];   // see R6
      smgm_pkg::SPL_END_IMM:      type_ok = cfg_r.accept[`SMGM_ACC_END_IMM];      // see R7
      default:                    type_ok = 1'b0;                                // see R8
    endcase
  end

  // every enabled criterion must hold for the same message
  assign hit = msg_valid && type_ok && ids_match(cfg_r, msg) &&
               (!cfg_r.dtmf_en || (msg.dtmf == cfg_r.dtmf_val)); // see R13, R1
  // cancel skips the dtmf test: its payload carries nothing to compare
  assign cancel_hit = msg_valid && cfg_r.cancel_en &&
                      (msg.splice_type == smgm_pkg::SPL_CANCEL) &&
                      ids_match(cfg_r, msg); // see R9

  always_comb begin
    state_nxt  = state_r;
    gpio_nxt   = gpio_r;
    dvalid_nxt = 1'b0;
    dtmf_nxt   = dtmf_r;
    dhold_nxt  = dhold_r;
    dsend_nxt  = dsend_r;
    pend_nxt   = pend_r;
    canc_nxt   = 1'b0;
    tmr_load   = 1'b0;
    tmr_ms     = '0;
    tmr_abort  = 1'b0;
    if (cancel_hit) begin
      // revoke whatever is waiting or already driven
      if (state_r != ST_IDLE) canc_nxt = 1'b1; // see R9
      tmr_abort = 1'b1;
      gpio_nxt  = 1'b0;
      pend_nxt  = 1'b0;
      state_nxt = ST_IDLE;
    end else if (hit) begin
      // the newest matching message replaces an older one
      tmr_load  = 1'b1;
      tmr_ms    = wait_ms(cfg_r, msg); // see R10, R11, R12
      dhold_nxt = msg.dtmf;
      dsend_nxt = cfg_r.dtmf_en; // see R1
      gpio_nxt  = 1'b0;
      pend_nxt  = 1'b1;
      state_nxt = ST_WAIT;
    end else begin
      case (state_r)
        ST_IDLE: begin
          pend_nxt = 1'b0;
        end
        // the timer adds two cycles of latency on top of the wait
        ST_WAIT: begin
          if (tmr_expire) begin
            gpio_nxt  = 1'b1; // see R4, R5, R6, R7, R11
            pend_nxt  = 1'b0;
            tmr_load  = 1'b1;
            tmr_ms    = MS_W'(PULSE_MS);
            state_nxt = ST_PULSE;
            if (dsend_r) begin
              dvalid_nxt = 1'b1; // see R1
              dtmf_nxt   = dhold_r;
            end
          end
        end
        // fixed pulse length; only a cancel or a new hit cuts it short
        ST_PULSE: begin
          if (tmr_expire) begin
            gpio_nxt  = 1'b0;
            state_nxt = ST_IDLE;
          end
        end
        default: begin
          gpio_nxt  = 1'b0;
          pend_nxt  = 1'b0;
          state_nxt = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r  <= ST_IDLE;
      gpio_r   <= 1'b0;
      dvalid_r <= 1'b0;
      dtmf_r   <= '0;
      dhold_r  <= '0;
      dsend_r  <= 1'b0;
      pend_r   <= 1'b0;
      canc_r   <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      gpio_r   <= gpio_nxt;
      dvalid_r <= dvalid_nxt;
      dtmf_r   <= dtmf_nxt;
      dhold_r  <= dhold_nxt;
      dsend_r  <= dsend_nxt;
      pend_r   <= pend_nxt;
      canc_r   <= canc_nxt;
    end
  end

  // one shared timer: a new hit reloads it, so only the newest message fires
  smgm_ms_timer #(
    .CYC_PER_MS (CYC_PER_MS),
    .MS_W       (MS_W)
  ) u_timer (
    .clk     (clk),
    .rstn    (rstn),
    .load    (tmr_load),
    .load_ms (tmr_ms),
    .abort   (tmr_abort),
    .expire  (tmr_expire)
  );

  // every output is a register, so downstream sees no decode glitches
  assign cfg_out    = cfg_r;
  assign gpio_out   = gpio_r;
  assign dtmf_valid = dvalid_r;
  assign dtmf_out   = dtmf_r;
  assign pending    = pend_r;
  assign cancelled  = canc_r;
endmodule : smgm_matcher

// *** smgm_src.sv ***
// message source model feeding the matcher
`timescale 1ns/100ps
module smgm_src (
  input  wire logic           clk,
  output logic                msg_valid,
  output smgm_pkg::smgm_msg_t msg
);
  initial begin
    msg_valid = 1'b0;
    msg       = '0;
  end
  // released fields show the inverse so a stale copy can never pass for a fresh one
  task automatic send(input smgm_pkg::smgm_msg_t m);
    @(negedge clk);
    msg_valid = 1'b1;
    msg       = m;
    @(negedge clk);
    msg_valid = 1'b0;
    msg       = ~m;
  endtask : send
endmodule : smgm_src

// *** smgm_checker.sv ***
// port assertions for the splice message matcher
`timescale 1ns/100ps
module smgm_checker #(
  parameter int CYC_PER_MS = 4,
  parameter int PULSE_MS   = 3
) (
  input wire logic                clk,
  input wire logic                rstn,
  input wire logic                msg_valid,
  input wire smgm_pkg::smgm_msg_t msg,
  input wire logic                cfg_wr,
  input wire smgm_pkg::smgm_cfg_t cfg_in,
  input wire smgm_pkg::smgm_cfg_t cfg_out,
  input wire logic                gpio_out,
  input wire logic                dtmf_valid,
  input wire logic [31:0]         dtmf_out,
  input wire logic                pending,
  input wire logic                cancelled
);
  localparam int PRE_LAT = CYC_PER_MS + 2;
  logic nc, idle, acc, nrm;
  assign nc   = !cfg_out.sid_en && !cfg_out.pid_en && !cfg_out.dtmf_en;
  assign idle = !pending && !gpio_out;
  assign acc  = msg.splice_type < 4 && cfg_out.accept[msg.splice_type[1:0]];
  assign nrm  = msg_valid && msg.splice_type == smgm_pkg::SPL_START_NORMAL && acc && nc;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  int hi_cnt_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hi_cnt_r <= 0;
    end else begin
      hi_cnt_r <= gpio_out ? hi_cnt_r + 1 : 0;
    end
  end
  property p_len;
    gpio_out |-> hi_cnt_r < PULSE_MS * CYC_PER_MS + 2;
  endproperty
  property p_imm;
    msg_valid && msg.splice_type == smgm_pkg::SPL_START_IMM && acc && nc
      |=> pending ##2 $rose(gpio_out);
  endproperty
  property p_rej;
    msg_valid && !acc && idle |=> !pending;
  endproperty
  property p_sid;
    msg_valid && cfg_out.sid_en && msg.splice_id != cfg_out.sid_val && idle |=> !pending;
  endproperty
  property p_pid;
    msg_valid && cfg_out.pid_en && msg.program_id != cfg_out.pid_val && idle |=> !pending;
  endproperty
  property p_dv;
    dtmf_valid |-> $rose(gpio_out);
  endproperty
  property p_can;
    msg_valid && msg.splice_type == smgm_pkg::SPL_CANCEL && cfg_out.cancel_en && !idle
      && !cfg_out.sid_en && !cfg_out.pid_en |=> cancelled && !gpio_out && !pending;
  endproperty
  property p_ign;
    nrm && cfg_out.ignore_preroll |=> pending ##2 $rose(gpio_out);
  endproperty
  property p_pre;
    nrm && !cfg_out.ignore_preroll && msg.preroll_ms == 1 && cfg_out.delay_ms == 0
      |=> pending ##PRE_LAT $rose(gpio_out);
  endproperty
  a_imm: assert property (p_imm) else $error("immediate trigger late");
  a_rej: assert property (p_rej) else $error("unaccepted type armed");
  a_sid: assert property (p_sid) else $error("splice id mismatch armed");
  a_pid: assert property (p_pid) else $error("program id mismatch armed");
  a_dv: assert property (p_dv) else $error("dtmf pulse off gpio rise");
  a_can: assert property (p_can) else $error("cancel not applied");
  a_ign: assert property (p_ign) else $error("preroll not ignored");
  a_pre: assert property (p_pre) else $error("preroll wait wrong");
  a_len: assert property (p_len) else $error("gpio pulse too long");
  c_can: cover property (cancelled);
  c_dtmf: cover property (dtmf_valid);
  c_rise: cover property ($rose(gpio_out));
endmodule : smgm_checker

// *** tb.sv ***
// self-checking bench for the splice message matcher
`timescale 1ns/100ps
module tb;
  localparam int CPM = 4;
  logic                clk, rstn, msg_valid, cfg_wr, gpio_out, dtmf_valid, pending, cancelled;
  logic [31:0]         dtmf_out;
  logic [15:0]         r, s;
  smgm_pkg::smgm_msg_t msg, m;
  smgm_pkg::smgm_cfg_t cfg_in, cfg_out, c;
  int                  n_errors, checks, cyc, n;
  smgm_matcher #(.CYC_PER_MS(CPM), .PULSE_MS(3)) i_dut (.clk, .rstn, .msg_valid, .msg,
    .cfg_wr, .cfg_in, .cfg_out, .gpio_out, .dtmf_valid, .dtmf_out, .pending, .cancelled);
  smgm_src i_src (.clk, .msg_valid, .msg);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    for (int i = 0; i < 8; i++) v = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    return v;
  endfunction : lfsr
  // en is {ignore, sid, pid, dtmf}; bad marks which message fields miss
  function automatic int exp_lat(input logic [2:0] ty, input logic [3:0] acc, en,
                                 input logic [2:0] bad, input int w);
    if (ty > 3 || !acc[ty[1:0]] || |(en[2:0] & bad)) return -1;
    return 2 + ((ty[0] || en[3] || w < 0) ? 0 : w * CPM);
  endfunction : exp_lat
  task chk(input logic [95:0] got, input logic [95:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  task final_report();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report
  task t(input logic [2:0] ty, input logic [3:0] acc, en, input logic [2:0] bad,
         input logic [15:0] pre, input logic signed [15:0] dl);
    int e;
    c = '0;
    c.accept = acc;
    {c.ignore_preroll, c.sid_en, c.pid_en, c.dtmf_en} = en;
    c.sid_val = 16'h0005;
    c.pid_val = 16'h0007;
    c.dtmf_val = 32'h0000_0009;
    c.delay_ms = dl;
    c.cancel_en = 1'b1;
    m.splice_type = smgm_pkg::smgm_splice_t'(ty);
    m.splice_id = {15'h0002, ~bad[2]};
    m.program_id = {15'h0003, ~bad[1]};
    m.dtmf = {31'h0000_0004, ~bad[0]};
    m.preroll_ms = pre;
    e = exp_lat(ty, acc, en, bad, int'(pre) + int'(dl));
    @(negedge clk);
    cfg_in = c;
    cfg_wr = 1'b1;
    @(negedge clk);
    cfg_wr = 1'b0;
    chk(cfg_out, c);
    i_src.send(m);
    for (n = 1; n < 40; n++) begin
      @(posedge clk);
      #1;
      if (gpio_out) break;
    end
    chk(gpio_out ? n : -1, e);
    if (gpio_out) begin
      chk({dtmf_valid, dtmf_out & {32{en[0]}}}, {en[0], m.dtmf & {32{en[0]}}});
      // pulse of 3 ms at CPM cycles each, plus the two-cycle timer latency
      for (n = 0; n < 40 && gpio_out; n++) begin
        @(posedge clk);
        #1;
      end
      chk(n, 2 + 3 * CPM);
    end
    for (n = 0; n < 40 && (gpio_out || pending); n++) @(posedge clk);
  endtask : t
  always @(posedge clk) begin
    cyc++;
    // generous ceiling: the whole sequence needs only a few thousand cycles
    if (cyc == 20000) begin
      n_errors++;
      final_report();
    end
  end
  initial begin
    rstn = 1'b0;
    cfg_wr = 1'b0;
    cfg_in = '0;
    r = 16'h3C20;
    repeat (20) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    c = '0;
    c.accept = 4'h3;
    chk(cfg_out, c);
    t(3'h0, 4'hF, 4'h0, 3'h0, 16'h0001, 16'h0000);
    t(3'h1, 4'hF, 4'h0, 3'h0, 16'h0005, 16'h0000);
    t(3'h2, 4'hF, 4'h0, 3'h0, 16'h0001, 16'hFFFF);
    t(3'h3, 4'hF, 4'h0, 3'h0, 16'h0002, 16'h0000);
    t(3'h0, 4'hF, 4'h8, 3'h0, 16'h0005, 16'h0000);
    t(3'h0, 4'hF, 4'h0, 3'h0, 16'h0001, 16'h0001);
    t(3'h0, 4'hF, 4'h0, 3'h0, 16'h0001, 16'hFFFB);
    t(3'h2, 4'h3, 4'h0, 3'h0, 16'h0000, 16'h0000);
    t(3'h1, 4'hF, 4'h4, 3'h4, 16'h0000, 16'h0000);
    t(3'h1, 4'hF, 4'h4, 3'h3, 16'h0000, 16'h0000);
    t(3'h1, 4'hF, 4'h2, 3'h2, 16'h0000, 16'h0000);
    t(3'h1, 4'hF, 4'h1, 3'h1, 16'h0000, 16'h0000);
    t(3'h1, 4'hF, 4'h7, 3'h0, 16'h0000, 16'h0000);
    t(3'h4, 4'hF, 4'h0, 3'h0, 16'h0000, 16'h0000);
    t(3'h0, 4'hF, 4'h0, 3'h0, 16'h0002, 16'h0000);
    i_src.send(m);
    repeat (2) @(posedge clk);
    m.splice_type = smgm_pkg::SPL_CANCEL;
    i_src.send(m);
    // cancelled stands for one cycle only: look before the next edge
    chk({cancelled, pending, gpio_out}, 3'h4);
    repeat (15) @(posedge clk);
    i_src.send(m);
    chk({cancelled, gpio_out}, 2'h0);
    repeat (40) begin
      r = lfsr(r);
      s = r;
      r = lfsr(r);
      t({r[8] & r[9], r[1:0]}, r[5:2], s[3:0], s[6:4], {14'h0, r[7:6]}, {{14{s[7]}}, s[9:8]});
    end
    final_report();
  end
endmodule : tb
bind smgm_matcher smgm_checker #(.CYC_PER_MS(CYC_PER_MS), .PULSE_MS(PULSE_MS)) i_chk (.clk,
  .rstn, .msg_valid, .msg, .cfg_wr, .cfg_in, .cfg_out, .gpio_out, .dtmf_valid, .dtmf_out,
  .pending, .cancelled);
